// File: shared/frt_map.vh
// Constants for the free-running timer, capture and interrupt block
`ifndef FRT_MAP_VH
`define FRT_MAP_VH

`define FRT_CLK_HZ       25000000
`define FRT_TICK_HZ      1000000
`define FRT_TICK_DIV     (`FRT_CLK_HZ / `FRT_TICK_HZ)
`define FRT_CNT_W        12
`define FRT_CNT_RST      12'h000
`define FRT_TAP_FAST_US  128
`define FRT_TAP_SLOW_US  1024
`define FRT_TAP_FAST_BIT 7
`define FRT_TAP_SLOW_BIT 10
`define FRT_CAP_W        8
`define FRT_CAP_SEL_W    3
`define FRT_CAP_MAX_SEL  3'h4
`define FRT_GPIO_W       16
`define FRT_IRQ_N        10
`define FRT_VEC_W        4
`define FRT_IRQ_BUSRST   0
`define FRT_IRQ_FAST     1
`define FRT_IRQ_SLOW     2
`define FRT_IRQ_EP0      3
`define FRT_IRQ_EP1      4
`define FRT_IRQ_EP2      5
`define FRT_IRQ_CAPA     6
`define FRT_IRQ_CAPB     7
`define FRT_IRQ_WAKE     8
`define FRT_IRQ_GPIO     9

`endif

// File: hw/frt_timer_irq.v
// Free-running timer with capture units, GPIO edge interrupts and vectoring
//
// Notes on behaviour
// - A 12-bit counter advances once per 1 MHz tick and never needs restart.
// - Bits 7 and 10 of the counter give 128 us and 1.024 ms periodic events.
// - Each periodic event raises a request only while its enable is set.
// - The live count is visible on an output at all times.
// - Four capture registers store an 8-bit count slice chosen by a select.
// - Every capture that stores a value requests a capture interrupt.
// - Ten maskable sources are vectored, lowest index highest priority.
// - All GPIO pin events merge into one shared GPIO request.
// - A per-pin mask keeps masked pins from raising the GPIO request.
// - A per-pin polarity bit picks a rising or falling edge as trigger.
// - Capture input A feeds unit A, capture input B feeds unit B.
`include "frt_map.vh"
`default_nettype none

module frt_timer_irq (
	input  wire                        sys_clk,
	input  wire                        sys_rst,
	input  wire                        capture_input_a,
	input  wire                        capture_input_b,
	input  wire [`FRT_CAP_SEL_W-1:0]   cap_slice_sel,
	input  wire                        cap_a_rise_en,
	input  wire                        cap_a_fall_en,
	input  wire                        cap_b_rise_en,
	input  wire                        cap_b_fall_en,
	input  wire                        tap_fast_en,
	input  wire                        tap_slow_en,
	input  wire [`FRT_GPIO_W-1:0]      gpio_in,
	input  wire [`FRT_GPIO_W-1:0]      gpio_irq_mask,
	input  wire [`FRT_GPIO_W-1:0]      gpio_irq_pol,
	input  wire                        bus_reset_req,
	input  wire [2:0]                  endpoint_req,
	input  wire                        wake_req,
	input  wire [`FRT_IRQ_N-1:0]       irq_enable,
	input  wire                        global_irq_en,
	input  wire                        irq_ack,
	output reg  [`FRT_CNT_W-1:0]       timer_count,
	output reg  [`FRT_CAP_W-1:0]       cap_a_rise_val,
	output reg  [`FRT_CAP_W-1:0]       cap_a_fall_val,
	output reg  [`FRT_CAP_W-1:0]       cap_b_rise_val,
	output reg  [`FRT_CAP_W-1:0]       cap_b_fall_val,
	output reg  [`FRT_IRQ_N-1:0]       irq_pending,
	output wire                        irq_req,
	output reg  [`FRT_VEC_W-1:0]       irq_vector
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Select an 8-bit window of the count; selects past the top clamp
	function [`FRT_CAP_W-1:0] slice_of;
		input [`FRT_CNT_W-1:0]     cnt;
		input [`FRT_CAP_SEL_W-1:0] sel;
		begin
			case (sel)
				3'h0: begin
					slice_of = cnt[7:0];
				end
				3'h1: begin
					slice_of = cnt[8:1];
				end
				3'h2: begin
					slice_of = cnt[9:2];
				end
				3'h3: begin
					slice_of = cnt[10:3];
				end
				default: begin
					// Top window; larger selects would run off the count
					slice_of = cnt[11:4];
				end
			endcase
		end
	endfunction

	// Index of the lowest set bit, for vector priority
	function [`FRT_VEC_W-1:0] first_set;
		input [`FRT_IRQ_N-1:0] v;
		integer                i;
		begin
			first_set = {`FRT_VEC_W{1'b0}};
			for (i = `FRT_IRQ_N - 1; i >= 0; i = i - 1) begin
				if (v[i]) begin
					first_set = i[`FRT_VEC_W-1:0];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Time base and free-running counter
	// ----------------------------------------------------------------

	localparam integer DIV_LAST = `FRT_TICK_DIV - 1;

	reg  [4:0]             div_reg;
	wire                   tick = (div_reg == DIV_LAST[4:0]);
	wire [`FRT_CNT_W-1:0]  count_next = timer_count + 12'h001;

	// Divider kept apart so the tick is one clock wide at any divide
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_reg <= 5'h00;
		end else begin
			div_reg <= tick ? 5'h00 : div_reg + 5'h01;
		end
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_count <= `FRT_CNT_RST;
		end else begin
			if (tick) begin
				timer_count <= count_next;
			end
		end
	end

	// Tap events fire when the bits below the tap bit carry into the tap bit
	wire fast_evt = tick && (count_next[`FRT_TAP_FAST_BIT-1:0] == 7'h00);
	wire slow_evt = tick && (count_next[`FRT_TAP_SLOW_BIT-1:0] == 10'h000);

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------

	reg [1:0]             cap_prev_reg;
	reg [`FRT_GPIO_W-1:0] gpio_prev_reg;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cap_prev_reg  <= 2'h0;
			gpio_prev_reg <= 16'h0000;
		end else begin
			cap_prev_reg  <= {capture_input_b, capture_input_a};
			gpio_prev_reg <= gpio_in;
		end
	end

	wire a_rise = capture_input_a & ~cap_prev_reg[0];
	wire a_fall = ~capture_input_a & cap_prev_reg[0];
	wire b_rise = capture_input_b & ~cap_prev_reg[1];
	wire b_fall = ~capture_input_b & cap_prev_reg[1];

	wire cap_a_a_store = a_rise & cap_a_rise_en;
	wire cap_a_f_store = a_fall & cap_a_fall_en;
	wire cap_b_r_store = b_rise & cap_b_rise_en;
	wire cap_b_f_store = b_fall & cap_b_fall_en;

	// Polarity 1 selects rising, 0 falling
	wire [`FRT_GPIO_W-1:0] gpio_rise = gpio_in & ~gpio_prev_reg;
	wire [`FRT_GPIO_W-1:0] gpio_fall = ~gpio_in & gpio_prev_reg;
	wire [`FRT_GPIO_W-1:0] gpio_hit =
		((gpio_rise & gpio_irq_pol) | (gpio_fall & ~gpio_irq_pol))
		& gpio_irq_mask;
	wire gpio_evt = |gpio_hit;

	// ----------------------------------------------------------------
	// Capture registers
	// ----------------------------------------------------------------

	wire [`FRT_CAP_W-1:0] cur_slice = slice_of(timer_count, cap_slice_sel);

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cap_a_rise_val <= 8'h00;
			cap_a_fall_val <= 8'h00;
			cap_b_rise_val <= 8'h00;
			cap_b_fall_val <= 8'h00;
		end else begin
			if (cap_a_a_store) begin
				cap_a_rise_val <= cur_slice;
			end
			if (cap_a_f_store) begin
				cap_a_fall_val <= cur_slice;
			end
			if (cap_b_r_store) begin
				cap_b_rise_val <= cur_slice;
			end
			if (cap_b_f_store) begin
				cap_b_fall_val <= cur_slice;
			end
		end
	end

	// ----------------------------------------------------------------
	// Vectored interrupt controller
	// ----------------------------------------------------------------

	reg [`FRT_IRQ_N-1:0] src_evt;

	always @* begin
		src_evt = {`FRT_IRQ_N{1'b0}};
		src_evt[`FRT_IRQ_BUSRST] = bus_reset_req;
		src_evt[`FRT_IRQ_FAST]   = fast_evt & tap_fast_en;
		src_evt[`FRT_IRQ_SLOW]   = slow_evt & tap_slow_en;
		src_evt[`FRT_IRQ_EP0]    = endpoint_req[0];
		src_evt[`FRT_IRQ_EP1]    = endpoint_req[1];
		src_evt[`FRT_IRQ_EP2]    = endpoint_req[2];
		src_evt[`FRT_IRQ_CAPA]   = cap_a_a_store | cap_a_f_store;
		src_evt[`FRT_IRQ_CAPB]   = cap_b_r_store | cap_b_f_store;
		src_evt[`FRT_IRQ_WAKE]   = wake_req;
		src_evt[`FRT_IRQ_GPIO]   = gpio_evt;
	end

	wire [`FRT_IRQ_N-1:0] active = irq_pending & irq_enable;
	wire [`FRT_VEC_W-1:0] best   = first_set(active);
	reg  [`FRT_IRQ_N-1:0] ack_clr;

	always @* begin
		ack_clr = {`FRT_IRQ_N{1'b0}};
		if (irq_ack) begin
			ack_clr[best] = 1'b1;
		end
	end

	// A fresh event wins over the acknowledge that clears its flag
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_pending <= 10'h000;
			irq_vector  <= 4'h0;
		end else begin
			irq_pending <= (irq_pending & ~ack_clr) | src_evt;
			irq_vector  <= best;
		end
	end

	// Request is held off while the core has interrupts disabled
	assign irq_req = global_irq_en & (|active);

endmodule

`default_nettype wire

// File: verif/frt_props_properties.sv
// Concurrent checks on the timer, capture and interrupt ports
`default_nettype none
module frt_props (
	input wire logic        sys_clk, sys_rst, capture_input_a,
	input wire logic        capture_input_b, cap_a_rise_en, cap_b_fall_en,
	input wire logic        tap_fast_en, tap_slow_en, global_irq_en, irq_req,
	input wire logic [2:0]  cap_slice_sel,
	input wire logic [15:0] gpio_in, gpio_irq_mask, gpio_irq_pol,
	input wire logic [9:0]  irq_enable, irq_pending,
	input wire logic [11:0] timer_count,
	input wire logic [7:0]  cap_a_rise_val, cap_b_fall_val,
	input wire logic [3:0]  irq_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] gpio_d;
	wire [9:0] act = irq_pending & irq_enable;
	// Lowest set bit stands for the winning source
	wire [9:0] low = act & (~act + 10'h001);
	wire [2:0] sh = (cap_slice_sel > 3'h4) ? 3'h4 : cap_slice_sel;
	wire [7:0] slc = 8'(timer_count >> sh);
	wire [15:0] ev = gpio_irq_mask & (gpio_irq_pol & gpio_in & ~gpio_d
		| ~gpio_irq_pol & ~gpio_in & gpio_d);
	always @(posedge sys_clk or posedge sys_rst)
		gpio_d <= sys_rst ? 16'h0000 : gpio_in;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_REQ: assert property (irq_req == (global_irq_en && act != 0))
		else $error("irq_req wrong");
	AST_STEP: assert property ($changed(timer_count) |->
		timer_count == $past(timer_count) + 12'h001) else $error("bad step");
	AST_HOLD: assert property ($changed(timer_count) |=>
		$stable(timer_count)[*8]) else $error("count too fast");
	AST_FAST: assert property ($rose(irq_pending[1]) |->
		timer_count[6:0] == 7'h00 && $past(tap_fast_en)) else $error("fast");
	AST_SLOW: assert property ($rose(irq_pending[2]) |->
		timer_count[9:0] == 10'h000 && $past(tap_slow_en)) else $error("slow");
	AST_VEC: assert property ($past(act) != 10'h000 |->
		(10'h001 << irq_vector) == $past(low)) else $error("bad vector");
	AST_CAPA: assert property ($rose(capture_input_a) && cap_a_rise_en |=>
		irq_pending[6] && cap_a_rise_val == $past(slc))
		else $error("capture a");
	AST_CAPB: assert property ($fell(capture_input_b) && cap_b_fall_en |=>
		irq_pending[7] && cap_b_fall_val == $past(slc))
		else $error("capture b");
	AST_GPIO: assert property ($rose(irq_pending[9]) |->
		$past(ev) != 16'h0000) else $error("gpio raised");
	AST_GSET: assert property (ev != 16'h0000 |=> irq_pending[9])
		else $error("gpio missed");
endmodule
`default_nettype wire

// File: verif/frt_core_model.sv
// Processor core stand-in that acknowledges interrupt requests
`default_nettype none
module frt_core_model (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       ack_on,
	input  wire logic [3:0] ack_delay,
	input  wire logic       irq_req,
	output var  logic       irq_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_reg;
	// Delay must stay above one: the vector lags pending by a cycle
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst || irq_ack || !(ack_on && irq_req)) begin
			irq_ack <= 1'b0;
			wait_reg <= 4'h0;
		end else if (wait_reg >= ack_delay) begin
			irq_ack <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: verif/tb_frt_timer_irq.sv
// Self-checking bench for the free-running timer block
`default_nettype none
module tb_frt_timer_irq;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int pin; logic msk, pol, l0, l1, exp;} frt_row_t;
	frt_row_t rows [5] = '{'{0,1,1,0,1,1}, '{3,0,1,0,1,0},
		'{9,1,1,1,0,0}, '{15,1,0,1,0,1}, '{7,1,0,0,1,0}};
	logic sys_clk = 0, sys_rst = 1, capture_input_a = 0, capture_input_b = 0;
	logic tap_fast_en = 0, tap_slow_en = 0, global_irq_en = 0, ack_on = 0;
	logic bus_reset_req = 0, wake_req = 0, irq_ack, irq_req;
	logic [2:0] cap_slice_sel = 0, endpoint_req = 0;
	logic [3:0] cap_en = 4'hF, ack_delay = 4'h2, irq_vector;
	logic [15:0] gpio_in = 0, gpio_irq_mask = 0, gpio_irq_pol = 0;
	logic [9:0] irq_enable = 0, irq_pending;
	logic [11:0] timer_count, e [3];
	logic [7:0] ar, af, br, bf;
	int errors = 0, checks = 0, n = 0, i;
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk or posedge sys_rst) n <= sys_rst ? 0 : n + 1;
	frt_timer_irq i_frt_timer_irq (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
		.cap_slice_sel(cap_slice_sel), .cap_a_rise_en(cap_en[0]),
		.cap_a_fall_en(cap_en[1]), .cap_b_rise_en(cap_en[2]),
		.cap_b_fall_en(cap_en[3]), .tap_fast_en(tap_fast_en),
		.tap_slow_en(tap_slow_en), .gpio_in(gpio_in),
		.gpio_irq_mask(gpio_irq_mask), .gpio_irq_pol(gpio_irq_pol),
		.bus_reset_req(bus_reset_req), .endpoint_req(endpoint_req),
		.wake_req(wake_req), .irq_enable(irq_enable),
		.global_irq_en(global_irq_en), .irq_ack(irq_ack),
		.timer_count(timer_count), .cap_a_rise_val(ar), .cap_a_fall_val(af),
		.cap_b_rise_val(br), .cap_b_fall_val(bf), .irq_pending(irq_pending),
		.irq_req(irq_req), .irq_vector(irq_vector));
	frt_core_model i_frt_core_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ack_on(ack_on), .ack_delay(ack_delay), .irq_req(irq_req),
		.irq_ack(irq_ack));
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [11:0] x, g);
		checks++;
		if (g !== x) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic reset(input int k);
		sys_rst = 1;
		tick(k);
		sys_rst = 0;
	endtask
	// Count seen by the capturing edge, from the bench's own cycle tally
	function automatic logic [11:0] exp_slice(input int s);
		return 12'(((n / 25) >> (s > 4 ? 4 : s)) & 255);
	endfunction
	initial begin
		#2000000;
		errors++;
		print_verdict();
	end
	initial begin
		reset(20);
		chk("count", 12'h000, timer_count);
		chk("pending", 12'h000, {2'b00, irq_pending});
		foreach (rows[r]) begin
			gpio_irq_mask = 0;
			gpio_in = 16'(rows[r].l0) << rows[r].pin;
			reset(2);
			tick(3);
			gpio_irq_mask = 16'(rows[r].msk) << rows[r].pin;
			gpio_irq_pol = 16'(rows[r].pol) << rows[r].pin;
			tick(2);
			gpio_in = 16'(rows[r].l1) << rows[r].pin;
			tick(3);
			chk("gpio", 12'(rows[r].exp), 12'(irq_pending[9]));
		end
		tick(999 - n);
		chk("count", 12'h027, timer_count);
		tick(1);
		chk("count", 12'h028, timer_count);
		tick(3202 - n);
		chk("fast", 12'h000, 12'(irq_pending[1]));
		tap_fast_en = 1;
		tick(6398 - n);
		chk("fast", 12'h000, 12'(irq_pending[1]));
		tap_slow_en = 1;
		tick(4);
		chk("fast", 12'h001, 12'(irq_pending[1]));
		tick(25598 - n);
		chk("slow", 12'h000, 12'(irq_pending[2]));
		tick(4);
		chk("slow", 12'h001, 12'(irq_pending[2]));
		for (i = 0; i < 6; i++) begin
			cap_slice_sel = 3'(i);
			capture_input_a = 1;
			e[0] = exp_slice(i);
			tick(30);
			capture_input_a = 0;
			capture_input_b = 1;
			e[1] = exp_slice(i);
			tick(30);
			capture_input_b = 0;
			e[2] = exp_slice(i);
			tick(3);
			chk("cap_a_rise", e[0], 12'(ar));
			chk("cap_a_fall", e[1], 12'(af));
			chk("cap_b_rise", e[1], 12'(br));
			chk("cap_b_fall", e[2], 12'(bf));
		end
		tap_fast_en = 0;
		irq_enable = 10'h1FF;
		gpio_irq_mask = 16'hFFFF;
		gpio_irq_pol = 16'hFFFF;
		gpio_in = 16'h0010;
		bus_reset_req = 1;
		endpoint_req = 3'h7;
		wake_req = 1;
		tick(1);
		bus_reset_req = 0;
		endpoint_req = 0;
		wake_req = 0;
		tick(2);
		chk("pending", 12'h3FF, {2'b00, irq_pending});
		chk("irq_req", 12'h000, 12'(irq_req));
		global_irq_en = 1;
		ack_on = 1;
		for (i = 0; i < 300 && irq_pending !== 10'h200; i++) tick(1);
		chk("pending", 12'h200, {2'b00, irq_pending});
		chk("irq_req", 12'h000, 12'(irq_req));
		ack_delay = 4'h9;
		irq_enable = 10'h3FF;
		for (i = 0; i < 300 && irq_pending !== 10'h000; i++) tick(1);
		chk("pending", 12'h000, {2'b00, irq_pending});
		print_verdict();
	end
endmodule
bind frt_timer_irq frt_props i_frt_props (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .capture_input_a(capture_input_a),
	.capture_input_b(capture_input_b), .cap_a_rise_en(cap_a_rise_en),
	.cap_b_fall_en(cap_b_fall_en), .tap_fast_en(tap_fast_en),
	.tap_slow_en(tap_slow_en), .global_irq_en(global_irq_en),
	.irq_req(irq_req), .cap_slice_sel(cap_slice_sel), .gpio_in(gpio_in),
	.gpio_irq_mask(gpio_irq_mask), .gpio_irq_pol(gpio_irq_pol),
	.irq_enable(irq_enable), .irq_pending(irq_pending),
	.timer_count(timer_count), .cap_a_rise_val(cap_a_rise_val),
	.cap_b_fall_val(cap_b_fall_val), .irq_vector(irq_vector));
`default_nettype wire
